// >>> core/bmss_mode_sync.sv
`timescale 1ns/10ps

// Summary of operation
// R1: auto mode uses pulse skipping at light load with diode emulation.
// R2: forced fixed-frequency mode disables diode emulation, switches always.
// R3: sync mode tracks external clock unless on/off time limits forbid.
// R4: sync mode behaves like forced mode, diode emulation off.
// R5: level-dependent control never locks to an external clock.
// R6: level-dependent level takes effect after stable for settle time.
// R7: spread spectrum off during frequency foldback, back on after.
// R8: 100 kohm strap fixes auto mode without spread spectrum permanently.
// R9: fourth valid sync pulse completing enters pulse-dependent control.
// R10: pulse-dependent control stays until restart.
// R11: pulse control: high forced+SS, low auto+SS, clock sync no SS.
// R12: double pulse then high or low turns spread spectrum off.
// R13: controller shapes both double pulses like valid sync pulses.
// R14: pulse control auto/forced change takes effect after settle time.
// R15: controller applies valid sync train to enter pulse control.
// R16: enable below wake threshold keeps shutdown.
// R17: between wake and precision threshold: supply on, switch node idle.
// R18: above precision threshold with input above 3 V: switching.
// R19: frequency folds back when on/off time cannot hold the ratio.
// R20: default 2.1 MHz or 400 kHz; sync accepted 200 kHz to 2.2 MHz.
// R21: sync mode entered after 2048 valid sync cycles.
// R22: steady input for settle time leaves sync, spread spectrum on.
// R23: spread spectrum on at first sync edge, off at lock pulse.
// R24: mode and enable comparators pass two flops before decoding.
module bmss_mode_sync #(
    parameter int         SETTLE_CYC   = bmss_pkg::MODE_SETTLE_CYC,
    parameter int         LOCK_PULSES  = bmss_pkg::SYNC_LOCK_PULSES,
    parameter bit         FACTORY_HIGH = 1'b1
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              mode_sync_in,
    input  wire logic              strap_100k,
    input  wire logic              en_wake,
    input  wire logic              en_precise,
    input  wire logic              vin_ok,
    input  wire logic              time_limit,
    output bmss_pkg::bmss_ctrl_t   ctrl,
    output bmss_pkg::bmss_en_t     en_out
);

    localparam int IN_W = 6;
    localparam int I_SY = 5;
    localparam int I_ST = 4;
    localparam int I_WK = 3;
    localparam int I_PR = 2;
    localparam int I_VI = 1;
    localparam int I_LM = 0;

    if (SETTLE_CYC <= bmss_pkg::SYNC_MAX_CYC ||
        SETTLE_CYC >= (1 << bmss_pkg::CNT_W) - 1) begin
        $error("settle count out of range");
    end
    if (LOCK_PULSES <= bmss_pkg::PULSE_CTRL_PULSES ||
        LOCK_PULSES >= (1 << bmss_pkg::BURST_W)) begin
        $error("lock pulse count out of range");
    end

    logic [IN_W-1:0]          meta;
    logic [IN_W-1:0]          sy;
    logic                     prev_sync;
    logic [bmss_pkg::CNT_W-1:0]   gap_cnt;
    logic [bmss_pkg::CNT_W-1:0]   quiet_cnt;
    logic [bmss_pkg::BURST_W-1:0] burst_cnt;
    logic [bmss_pkg::BURST_W-1:0] next_burst;
    logic [bmss_pkg::BURST_W-1:0] pulses_done;
    logic                     burst_active;
    logic                     pulse_ctrl;
    logic [1:0]               boot_cnt;
    logic                     strap_done;
    logic                     strap_fixed;
    bmss_pkg::bmss_mode_t     mode;
    logic                     ss;
    logic                     rise;
    logic                     fall;
    logic                     level;
    logic                     period_ok;
    logic                     settle_hit;

    // two-stage synchroniser for all comparator outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta <= '0;
            sy   <= '0;
        end else begin
            meta <= {mode_sync_in, strap_100k, en_wake, en_precise,
                     vin_ok, time_limit}; // R24
            sy   <= meta; // R24
        end
    end

    assign level = sy[I_SY];
    assign rise  = level & ~prev_sync;
    assign fall  = ~level & prev_sync;

    function automatic logic in_window(
        input logic [bmss_pkg::CNT_W-1:0] gap
    );
        logic [bmss_pkg::CNT_W-1:0] per;
        per = gap + 1'b1;
        return per >= bmss_pkg::CNT_W'(bmss_pkg::SYNC_MIN_CYC) &&
               per <= bmss_pkg::CNT_W'(bmss_pkg::SYNC_MAX_CYC);
    endfunction

    assign period_ok  = in_window(gap_cnt); // R20
    // a rise into a steady high level completes no pulse
    assign pulses_done = burst_cnt - bmss_pkg::BURST_W'(level);
    assign settle_hit = ~rise & ~fall &
                        quiet_cnt == bmss_pkg::CNT_W'(SETTLE_CYC - 1);

    always_comb begin
        next_burst = burst_cnt;
        if (rise) begin
            if (!burst_active || !period_ok)
                next_burst = bmss_pkg::BURST_W'(1);
            else if (burst_cnt != '1)
                next_burst = burst_cnt + 1'b1;
        end
    end

    // edge tracking and period measurement
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prev_sync    <= 1'b0;
            gap_cnt      <= '0;
            burst_cnt    <= '0;
            burst_active <= 1'b0;
        end else begin
            prev_sync <= level;
            burst_cnt <= next_burst;
            if (rise) begin
                gap_cnt      <= '0;
                burst_active <= 1'b1;
            end else begin
                if (gap_cnt != '1)
                    gap_cnt <= gap_cnt + 1'b1;
                if (gap_cnt >= bmss_pkg::CNT_W'(bmss_pkg::SYNC_MAX_CYC))
                    burst_active <= 1'b0;
            end
        end
    end

    // steady-level timer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quiet_cnt <= '0;
        end else if (rise || fall) begin
            quiet_cnt <= '0;
        end else if (quiet_cnt != bmss_pkg::CNT_W'(SETTLE_CYC)) begin
            quiet_cnt <= quiet_cnt + 1'b1;
        end
    end

    // strap caught once after reset release
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            boot_cnt    <= '0;
            strap_done  <= 1'b0;
            strap_fixed <= 1'b0;
        end else if (!strap_done) begin
            boot_cnt <= boot_cnt + 1'b1;
            if (boot_cnt == 2'(bmss_pkg::SYNC_STAGES)) begin
                strap_done  <= 1'b1;
                strap_fixed <= sy[I_ST]; // R8
            end
        end
    end

    // control scheme: level dependent until a valid train, then sticky
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pulse_ctrl <= 1'b0;
        end else if (fall && !strap_fixed && strap_done &&
                     burst_cnt >= bmss_pkg::BURST_W'(
                         bmss_pkg::PULSE_CTRL_PULSES)) begin
            pulse_ctrl <= 1'b1; // R9 R10
        end
    end

    // operating mode and spread spectrum selection
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode <= bmss_pkg::BMSS_AUTO;
            ss   <= 1'b1;
        end else if (strap_fixed) begin
            mode <= bmss_pkg::BMSS_AUTO; // R8
            ss   <= 1'b0; // R8
        end else if (!pulse_ctrl) begin
            if (settle_hit) begin
                mode <= level ? bmss_pkg::BMSS_FORCED
                              : bmss_pkg::BMSS_AUTO; // R5 R6
                ss   <= 1'b1;
            end
        end else if (rise && mode != bmss_pkg::BMSS_SYNC) begin
            if (next_burst >= bmss_pkg::BURST_W'(LOCK_PULSES)) begin
                mode <= bmss_pkg::BMSS_SYNC; // R11 R21
                ss   <= 1'b0; // R23
            end else begin
                ss   <= 1'b1; // R23
            end
        end else if (settle_hit) begin
            mode <= level ? bmss_pkg::BMSS_FORCED
                          : bmss_pkg::BMSS_AUTO; // R11 R14 R22
            if (mode == bmss_pkg::BMSS_SYNC)
                ss <= 1'b1; // R22
            else
                ss <= pulses_done != bmss_pkg::BURST_W'(
                          bmss_pkg::DOUBLE_PULSES); // R12
        end
    end

    // registered control outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl <= '0;
        end else begin
            ctrl.mode            <= mode;
            ctrl.spread_spectrum <= ss & ~sy[I_LM]; // R7
            ctrl.diode_emulation <= mode == bmss_pkg::BMSS_AUTO; // R1 R2 R4
            ctrl.pulse_skipping_operation <=
                mode == bmss_pkg::BMSS_AUTO; // R1
            ctrl.forced_fixed_frequency_mode <=
                mode != bmss_pkg::BMSS_AUTO; // R2 R4
            ctrl.track_ext_clock <=
                mode == bmss_pkg::BMSS_SYNC && !sy[I_LM]; // R3
            ctrl.freq_foldback   <= sy[I_LM]; // R19
            ctrl.pulse_dependent <= pulse_ctrl;
            ctrl.default_freq_khz <= FACTORY_HIGH ? bmss_pkg::FSW_HIGH_KHZ
                                                  : bmss_pkg::FSW_LOW_KHZ; // R20
        end
    end

    // enable decode
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            en_out <= '{bmss_pkg::BMSS_SHUTDOWN, 1'b0, 1'b0};
        end else if (!sy[I_WK]) begin
            en_out <= '{bmss_pkg::BMSS_SHUTDOWN, 1'b0, 1'b0}; // R16
        end else if (!(sy[I_PR] && sy[I_VI])) begin
            en_out <= '{bmss_pkg::BMSS_STANDBY, 1'b1, 1'b0}; // R17
        end else begin
            en_out <= '{bmss_pkg::BMSS_SWITCHING, 1'b1, 1'b1}; // R18
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_level_no_sync: assert property ( // R5
        !pulse_ctrl |-> mode != bmss_pkg::BMSS_SYNC)
        else $error("sync mode under level control");
    a_pulse_sticky: assert property ( // R10
        pulse_ctrl |=> pulse_ctrl [*8])
        else $error("pulse control dropped");
    a_fourth_pulse: assert property ( // R9
        fall && strap_done && !strap_fixed &&
        burst_cnt >= bmss_pkg::BURST_W'(bmss_pkg::PULSE_CTRL_PULSES)
        |=> pulse_ctrl)
        else $error("fourth pulse did not enter pulse control");
    a_strap_fixed: assert property ( // R8
        strap_fixed |=> ##1 ctrl.mode == bmss_pkg::BMSS_AUTO &&
                        !ctrl.spread_spectrum)
        else $error("strap choice not held");
    a_foldback_ss: assert property ( // R7
        sy[I_LM] |=> !ctrl.spread_spectrum && ctrl.freq_foldback)
        else $error("spread spectrum active in foldback");
    a_auto_diode: assert property ( // R1
        mode == bmss_pkg::BMSS_AUTO |=> ctrl.diode_emulation &&
        ctrl.pulse_skipping_operation)
        else $error("auto mode without diode emulation");
    a_forced_no_diode: assert property ( // R2
        mode != bmss_pkg::BMSS_AUTO |=> !ctrl.diode_emulation &&
        ctrl.forced_fixed_frequency_mode)
        else $error("diode emulation outside auto mode");
    a_sync_track: assert property ( // R3
        mode == bmss_pkg::BMSS_SYNC && !sy[I_LM] |=> ctrl.track_ext_clock)
        else $error("sync mode not tracking");
    a_level_settle: assert property ( // R6
        settle_hit && !pulse_ctrl && !strap_fixed && level
        |=> mode == bmss_pkg::BMSS_FORCED)
        else $error("level high not applied after settle");
    a_sync_lock: assert property ( // R21
        pulse_ctrl && !strap_fixed && rise &&
        next_burst == bmss_pkg::BURST_W'(LOCK_PULSES) &&
        mode != bmss_pkg::BMSS_SYNC
        |=> mode == bmss_pkg::BMSS_SYNC && !ss)
        else $error("no sync lock at lock pulse");
    a_sync_drop: assert property ( // R22
        mode == bmss_pkg::BMSS_SYNC && settle_hit && !strap_fixed
        |=> mode != bmss_pkg::BMSS_SYNC && ss)
        else $error("steady input did not leave sync");
    a_double_pulse: assert property ( // R12
        pulse_ctrl && !strap_fixed && mode != bmss_pkg::BMSS_SYNC &&
        settle_hit &&
        pulses_done == bmss_pkg::BURST_W'(bmss_pkg::DOUBLE_PULSES)
        |=> !ss)
        else $error("double pulse kept spread spectrum");
    a_en_shutdown: assert property ( // R16
        !sy[I_WK] |=> en_out.state == bmss_pkg::BMSS_SHUTDOWN &&
        !en_out.vcc_enable)
        else $error("not in shutdown below wake");
    a_en_standby: assert property ( // R17
        sy[I_WK] && !sy[I_PR] |=> en_out.vcc_enable &&
        !en_out.switch_node_enable)
        else $error("standby decode wrong");
    a_en_switch: assert property ( // R18
        sy[I_WK] && sy[I_PR] && sy[I_VI] |=> en_out.switch_node_enable)
        else $error("switching not enabled");
    a_strap_blocks: assert property ( // R8
        strap_fixed |-> !pulse_ctrl)
        else $error("pulse control entered despite strap");
    a_sync_no_diode: assert property ( // R4
        mode == bmss_pkg::BMSS_SYNC |=> !ctrl.diode_emulation &&
        ctrl.forced_fixed_frequency_mode)
        else $error("sync mode with diode emulation");
    a_first_edge_ss: assert property ( // R23
        pulse_ctrl && !strap_fixed && rise &&
        mode != bmss_pkg::BMSS_SYNC &&
        next_burst < bmss_pkg::BURST_W'(LOCK_PULSES) |=> ss)
        else $error("spread spectrum off after sync edge");
    a_pulse_high: assert property ( // R11 R14
        pulse_ctrl && !strap_fixed && settle_hit && level
        |=> mode == bmss_pkg::BMSS_FORCED)
        else $error("steady high not applied under pulse control");
    a_pulse_low: assert property ( // R11 R14
        pulse_ctrl && !strap_fixed && settle_hit && !level
        |=> mode == bmss_pkg::BMSS_AUTO)
        else $error("steady low not applied under pulse control");
    a_level_low: assert property ( // R6
        settle_hit && !pulse_ctrl && !strap_fixed && !level
        |=> mode == bmss_pkg::BMSS_AUTO)
        else $error("level low not applied after settle");
    a_ss_restore: assert property ( // R7
        ss && !sy[I_LM] |=> ctrl.spread_spectrum)
        else $error("spread spectrum not restored after foldback");
    a_en_vin_low: assert property ( // R18
        !sy[I_VI] |=> !en_out.switch_node_enable)
        else $error("switching without input supply");

    c_pulse_entry: cover property (!pulse_ctrl ##1 pulse_ctrl);
    c_sync_lock: cover property (
        mode != bmss_pkg::BMSS_SYNC ##1 mode == bmss_pkg::BMSS_SYNC);
    c_double_off: cover property (pulse_ctrl && ss ##1 pulse_ctrl && !ss);
    c_switching: cover property (
        en_out.state == bmss_pkg::BMSS_SWITCHING);
    c_foldback: cover property (ctrl.freq_foldback);

endmodule

// >>> pkg/bmss_pkg.sv
package bmss_pkg;

    // oscillator clock and sync window
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SYNC_FMAX_KHZ   = 2200;
    localparam int SYNC_FMIN_KHZ   = 200;
    localparam int SYNC_TMIN_NS    = 1000000 / SYNC_FMAX_KHZ;
    localparam int SYNC_TMAX_NS    = 1000000 / SYNC_FMIN_KHZ;
    localparam int SYNC_MIN_CYC    =
        (SYNC_TMIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_MAX_CYC    = SYNC_TMAX_NS / CLK_PERIOD_NS;

    // mode settle time
    localparam int MODE_SETTLE_NS  = 100000;
    localparam int MODE_SETTLE_CYC = MODE_SETTLE_NS / CLK_PERIOD_NS;

    // pulse counts
    localparam int PULSE_CTRL_PULSES = 4;
    localparam int SYNC_LOCK_PULSES  = 2048;
    localparam int DOUBLE_PULSES     = 2;

    // factory default frequencies
    localparam logic [11:0] FSW_HIGH_KHZ = 12'h834;
    localparam logic [11:0] FSW_LOW_KHZ  = 12'h190;

    localparam int SYNC_STAGES = 2;
    localparam int CNT_W       = 16;
    localparam int BURST_W     = 12;

    typedef enum logic [1:0] {
        BMSS_AUTO   = 2'b00,
        BMSS_FORCED = 2'b01,
        BMSS_SYNC   = 2'b10
    } bmss_mode_t;

    typedef enum logic [1:0] {
        BMSS_SHUTDOWN  = 2'b00,
        BMSS_STANDBY   = 2'b01,
        BMSS_SWITCHING = 2'b10
    } bmss_en_state_t;

    typedef struct packed {
        bmss_mode_t  mode;
        logic        spread_spectrum;
        logic        diode_emulation;
        logic        pulse_skipping_operation;
        logic        forced_fixed_frequency_mode;
        logic        track_ext_clock;
        logic        freq_foldback;
        logic        pulse_dependent;
        logic [11:0] default_freq_khz;
    } bmss_ctrl_t;

    typedef struct packed {
        bmss_en_state_t state;
        logic           vcc_enable;
        logic           switch_node_enable;
    } bmss_en_t;

endpackage

// >>> verification/bmss_link_model.sv
`timescale 1ns/10ps

// controller on the mode/sync line; link clock only runs within a frame
module bmss_link_model (
    input  wire logic        start,
    input  wire logic [11:0] n_pulses,
    input  wire logic        end_level,
    output logic             pin,
    output logic             busy
);
    int   i;

    initial begin
        pin  = 1'b0;
        busy = 1'b0;
    end

    // pin is the link clock itself: each pulse low then high for half of
    // 800 ns, so every rise is spaced one full valid period from the last
    always @(posedge start) begin
        busy = 1'b1;
        #137;
        for (i = 0; i < n_pulses; i++) begin
            pin = 1'b0;
            #400;
            pin = 1'b1;
            #400;
        end
        pin = 1'b0;
        #400;
        pin  = end_level;
        busy = 1'b0;
    end
endmodule

// >>> verification/bmss_mode_sync_tb.sv
`timescale 1ns/10ps

module bmss_mode_sync_tb;
    localparam int SETTLE = 60;
    localparam int LOCK   = 8;

    logic                 clock = 1'b0;
    logic                 reset = 1'b1;
    logic                 strap_100k = 1'b0;
    logic                 en_wake = 1'b0;
    logic                 en_precise = 1'b0;
    logic                 vin_ok = 1'b0;
    logic                 time_limit = 1'b0;
    logic                 start = 1'b0;
    logic [11:0]          n_pulses = 12'h000;
    logic                 end_level = 1'b0;
    logic                 pin;
    logic                 busy;
    logic [7:0]           rnd = 8'h42;
    bmss_pkg::bmss_ctrl_t ctrl;
    bmss_pkg::bmss_en_t   en_out;
    int                   error_cnt = 0;
    int                   tests_run = 0;

    always #50 clock = ~clock;

    bmss_mode_sync #(
        .SETTLE_CYC  (SETTLE),
        .LOCK_PULSES (LOCK),
        .FACTORY_HIGH(1'b1)
    ) u_bmss_mode_sync (
        .clock       (clock),
        .reset       (reset),
        .mode_sync_in(pin),
        .strap_100k  (strap_100k),
        .en_wake     (en_wake),
        .en_precise  (en_precise),
        .vin_ok      (vin_ok),
        .time_limit  (time_limit),
        .ctrl        (ctrl),
        .en_out      (en_out)
    );

    bmss_link_model u_bmss_link_model (
        .start    (start),
        .n_pulses (n_pulses),
        .end_level(end_level),
        .pin      (pin),
        .busy     (busy)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic bmss_pkg::bmss_ctrl_t exp_ctrl(
        input bmss_pkg::bmss_mode_t m, input logic ss,
        input logic lim, input logic pd);
        bmss_pkg::bmss_ctrl_t c;
        c.mode                        = m;
        c.spread_spectrum             = ss & ~lim;
        c.diode_emulation             = (m == bmss_pkg::BMSS_AUTO);
        c.pulse_skipping_operation    = (m == bmss_pkg::BMSS_AUTO);
        c.forced_fixed_frequency_mode = (m != bmss_pkg::BMSS_AUTO);
        c.track_ext_clock             = (m == bmss_pkg::BMSS_SYNC) & ~lim;
        c.freq_foldback               = lim;
        c.pulse_dependent             = pd;
        c.default_freq_khz            = bmss_pkg::FSW_HIGH_KHZ;
        return c;
    endfunction

    function automatic bmss_pkg::bmss_en_t exp_en(
        input logic w, input logic p, input logic v);
        bmss_pkg::bmss_en_t e;
        e.state = !w ? bmss_pkg::BMSS_SHUTDOWN :
                  (p && v) ? bmss_pkg::BMSS_SWITCHING :
                  bmss_pkg::BMSS_STANDBY;
        e.vcc_enable         = w;
        e.switch_node_enable = w & p & v;
        return e;
    endfunction

    task automatic chk_ctrl(input bmss_pkg::bmss_ctrl_t e);
        tests_run++;
        if (ctrl !== e) begin
            error_cnt++;
            $display("[FAIL] %0t ctrl got %h exp %h", $time, ctrl, e);
        end
    endtask

    task automatic chk_en(input bmss_pkg::bmss_en_t e);
        tests_run++;
        if (en_out !== e) begin
            error_cnt++;
            $display("[FAIL] %0t en_out got %h exp %h", $time, en_out, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic do_reset(input logic strap);
        @(negedge clock);
        reset      = 1'b1;
        strap_100k = strap;
        cyc(10);
        chk_ctrl('0);
        cyc(6);
        reset = 1'b0;
    endtask

    // waits on the model's busy flag under a bound
    task automatic send(input logic [11:0] n, input logic lvl);
        int k;
        @(negedge clock);
        n_pulses  = n;
        end_level = lvl;
        start     = 1'b1;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clock);
        start = 1'b0;
        for (k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clock);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end

    initial begin
        do_reset(1'b0);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 0));
        for (int j = 0; j < 12; j++) begin
            rnd        = lfsr(rnd);
            en_wake    = rnd[0];
            en_precise = rnd[0] & rnd[1];
            vin_ok     = rnd[2];
            cyc(5);
            chk_en(exp_en(en_wake, en_precise, vin_ok));
        end
        $display("test enable done");
        send(0, 1);
        cyc(30);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 0));
        cyc(40);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_FORCED, 1, 0, 0));
        time_limit = 1'b1;
        cyc(6);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_FORCED, 1, 1, 0));
        time_limit = 1'b0;
        cyc(6);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_FORCED, 1, 0, 0));
        send(3, 0);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 0));
        $display("test level control done");
        send(4, 0);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 1));
        send(2, 1);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_FORCED, 0, 0, 1));
        send(2, 0);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 0, 0, 1));
        send(1, 0);
        cyc(10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 1));
        send(12'(LOCK + 2), 1);
        cyc(5);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_SYNC, 0, 0, 1));
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_FORCED, 1, 0, 1));
        $display("test pulse control done");
        send(0, 0);
        do_reset(1'b0);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 1, 0, 0));
        do_reset(1'b1);
        send(4, 1);
        cyc(SETTLE + 10);
        chk_ctrl(exp_ctrl(bmss_pkg::BMSS_AUTO, 0, 0, 0));
        $display("test restart and strap done");
        complete_run();
    end
endmodule
